// >>> tx_hardware_configuration_regs.sv
// transmit control and hardware configuration registers with soft reset sequencer
`include "tx_hardware_configuration_consts.svh"
`default_nettype none
module tx_hardware_configuration_regs #(
  parameter int SOFTWARE_RESET_REQUEST_TIMEOUT_CYCLES = `SOFTWARE_RESET_REQUEST_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // transmitter side
  input wire logic TX_HALTED_I,
  input wire logic TX_STATUS_FULL_I,
  output logic TX_ENABLE_O,
  output logic TX_STOP_REQ_O,
  output logic TX_SUSPEND_O,
  output logic TX_STATUS_FULL_EVENT_O,
  output logic TX_STATUS_FLUSH_O,
  output logic TX_DATA_FLUSH_O,
  // fifo configuration
  output logic PORT_PATH_ENDIAN_O,
  output logic DIRECT_PATH_ENDIAN_O,
  output logic MUST_BE_ONE_O,
  output tx_hardware_configuration_pkg::fifo_bytes_t TX_DATA_FIFO_BYTES_O,
  output tx_hardware_configuration_pkg::fifo_bytes_t TX_STATUS_FIFO_BYTES_O,
  output tx_hardware_configuration_pkg::fifo_bytes_t RX_FIFO_BYTES_O,
  // pins and soft reset
  input wire logic AUTO_CROSSOVER_STRAP_I,
  input wire logic PHY_CLKS_RUNNING_I,
  output logic SOFT_RESET_O
);
  import tx_hardware_configuration_pkg::*;

  localparam int TMO_W = 16;
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(SOFTWARE_RESET_REQUEST_TIMEOUT_CYCLES - 1);

  // synchronised pins
  logic [1:0] pins_sync;
  logic strap_sync;
  logic phy_clks_run;

  sync_2ff #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .d_i({AUTO_CROSSOVER_STRAP_I, PHY_CLKS_RUNNING_I}),
    .q_o(pins_sync)
  );

  assign strap_sync = pins_sync[1];
  assign phy_clks_run = pins_sync[0];

  // register state
  logic stop_tx;
  logic tx_enable;
  logic overrun_allow;
  logic status_flush;
  logic data_flush;
  logic suspend;
  logic full_d;
  logic full_event;
  logic port_path_endian;
  logic direct_path_endian;
  logic must_be_one;
  alloc_size_t tx_allocation_size;
  logic auto_crossover_strap;
  logic [1:0] strap_wait;
  logic soft_reset_timeout;
  software_reset_request_state_t software_reset_request_state;
  software_reset_request_state_t next_software_reset_request_state;
  logic [TMO_W-1:0] tmo_cnt;
  logic [TMO_W-1:0] next_tmo_cnt;
  fifo_bytes_t tx_total_bytes;
  fifo_bytes_t tx_data_bytes;
  fifo_bytes_t rx_bytes;
  logic [31:0] rdata;
  logic rvalid;

  // decode
  wire wr_tx = REG_WR_I && (REG_ADDR_I == `TX_CTRL_OFFSET);
  wire wr_hw = REG_WR_I && (REG_ADDR_I == `HARDWARE_CONFIGURATION_OFFSET);
  wire rd_tx = REG_ADDR_I == `TX_CTRL_OFFSET;
  wire rd_hw = REG_ADDR_I == `HARDWARE_CONFIGURATION_OFFSET;
  wire [3:0] wr_alloc = REG_WDATA_I[`HWC_ALLOC_HI:`HWC_ALLOC_LO];
  wire alloc_ok = (wr_alloc >= `ALLOC_MIN) && (wr_alloc <= `ALLOC_MAX);
  wire soft_rst = software_reset_request_state == SR_FIRE;
  wire software_reset_request_busy = software_reset_request_state != SR_IDLE;
  wire software_reset_request_start = wr_hw && REG_WDATA_I[`HWC_SOFTWARE_RESET_REQUEST_BIT] && !software_reset_request_busy;
  wire halt_done = stop_tx && TX_HALTED_I;
  wire stop_accept = wr_tx && !stop_tx;

  // reserved fields and self-clearing flush bits read as zero
  wire [31:0] tx_cfg_read = {16'h0000, 2'b00, 11'h000, overrun_allow, tx_enable, stop_tx};
  wire [31:0] hardware_configuration_read = {2'b00, port_path_endian, direct_path_endian, 3'b000, auto_crossover_strap,
                             3'b000, must_be_one, tx_allocation_size, 14'h0000,
                             soft_reset_timeout, software_reset_request_busy};
  wire [31:0] read_mux = rd_tx ? tx_cfg_read : (rd_hw ? hardware_configuration_read : 32'h0000_0000);

  // transmit control: a halt seen together with a write drops the write
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stop_tx <= 1'b0;
      tx_enable <= 1'b0;
      overrun_allow <= 1'b0;
    end else if (soft_rst) begin
      stop_tx <= 1'b0;
      tx_enable <= 1'b0;
      overrun_allow <= 1'b0;
    end else if (halt_done) begin
      stop_tx <= 1'b0;
      tx_enable <= 1'b0;
    end else if (wr_tx) begin
      tx_enable <= REG_WDATA_I[`TXC_ENABLE_BIT];
      overrun_allow <= REG_WDATA_I[`TXC_OVERRUN_ALLOW_BIT];
      if (stop_accept) begin
        stop_tx <= REG_WDATA_I[`TXC_STOP_BIT];
      end
    end
  end

  // flush strobes and status-full handling
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      status_flush <= 1'b0;
      data_flush <= 1'b0;
      suspend <= 1'b0;
      full_d <= 1'b0;
      full_event <= 1'b0;
    end else begin
      status_flush <= wr_tx && REG_WDATA_I[`TXC_STATUS_FLUSH_BIT];
      data_flush <= wr_tx && REG_WDATA_I[`TXC_DATA_FLUSH_BIT];
      suspend <= TX_STATUS_FULL_I && !overrun_allow;
      full_d <= TX_STATUS_FULL_I;
      full_event <= TX_STATUS_FULL_I && !full_d;
    end
  end

  // endian selects survive soft reset
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      port_path_endian <= 1'b0;
      direct_path_endian <= 1'b0;
    end else if (wr_hw) begin
      port_path_endian <= REG_WDATA_I[`HWC_PORT_ENDIAN_BIT];
      direct_path_endian <= REG_WDATA_I[`HWC_DIRECT_ENDIAN_BIT];
    end
  end

  // reserved allocation codes are dropped so the split never goes out of range
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      must_be_one <= 1'b0;
      tx_allocation_size <= `ALLOC_RESET;
    end else if (soft_rst) begin
      must_be_one <= 1'b0;
      tx_allocation_size <= `ALLOC_RESET;
    end else if (wr_hw) begin
      must_be_one <= REG_WDATA_I[`HWC_MBO_BIT];
      if (alloc_ok) begin
        tx_allocation_size <= wr_alloc;
      end
    end
  end

  // fifo split
  assign tx_total_bytes = {1'b0, tx_allocation_size, 10'h000};
  assign tx_data_bytes = tx_total_bytes - `TX_STATUS_FIFO_BYTES;
  assign rx_bytes = `FIFO_MEM_BYTES - tx_total_bytes;

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TX_DATA_FIFO_BYTES_O <= 15'h0000;
      TX_STATUS_FIFO_BYTES_O <= 15'h0000;
      RX_FIFO_BYTES_O <= 15'h0000;
    end else begin
      TX_DATA_FIFO_BYTES_O <= tx_data_bytes;
      TX_STATUS_FIFO_BYTES_O <= `TX_STATUS_FIFO_BYTES;
      RX_FIFO_BYTES_O <= rx_bytes;
    end
  end

  // strap caught once, after the synchroniser has filled following reset release
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      strap_wait <= 2'h0;
      auto_crossover_strap <= 1'b0;
    end else if (strap_wait != 2'h3) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        auto_crossover_strap <= strap_sync;
      end
    end
  end

  // soft reset sequencer
  always_comb begin
    next_software_reset_request_state = software_reset_request_state;
    next_tmo_cnt = tmo_cnt;
    case (software_reset_request_state)
      SR_IDLE: begin
        next_tmo_cnt = '0;
        if (software_reset_request_start) begin
          next_software_reset_request_state = SR_WAIT;
        end
      end
      SR_WAIT: begin
        if (phy_clks_run) begin
          next_software_reset_request_state = SR_FIRE;
        end else if (tmo_cnt == TMO_LAST) begin
          next_software_reset_request_state = SR_IDLE;
        end else begin
          next_tmo_cnt = tmo_cnt + TMO_W'(1);
        end
      end
      SR_FIRE: begin
        next_software_reset_request_state = SR_IDLE;
      end
      default: begin
        next_software_reset_request_state = SR_IDLE;
      end
    endcase
  end

  wire tmo_hit = (software_reset_request_state == SR_WAIT) && !phy_clks_run && (tmo_cnt == TMO_LAST);

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      software_reset_request_state <= SR_IDLE;
      tmo_cnt <= '0;
      soft_reset_timeout <= 1'b0;
    end else begin
      software_reset_request_state <= next_software_reset_request_state;
      tmo_cnt <= next_tmo_cnt;
      if (tmo_hit) begin
        soft_reset_timeout <= 1'b1;
      end else if (software_reset_request_start) begin
        soft_reset_timeout <= 1'b0;
      end
    end
  end

  // read port
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata <= 32'h0000_0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= REG_RD_I;
      if (REG_RD_I) begin
        rdata <= read_mux;
      end
    end
  end

  assign REG_RDATA_O = rdata;
  assign REG_RVALID_O = rvalid;
  assign TX_ENABLE_O = tx_enable;
  assign TX_STOP_REQ_O = stop_tx;
  assign TX_SUSPEND_O = suspend;
  assign TX_STATUS_FULL_EVENT_O = full_event;
  assign TX_STATUS_FLUSH_O = status_flush;
  assign TX_DATA_FLUSH_O = data_flush;
  assign PORT_PATH_ENDIAN_O = port_path_endian;
  assign DIRECT_PATH_ENDIAN_O = direct_path_endian;
  assign MUST_BE_ONE_O = must_be_one;
  assign SOFT_RESET_O = soft_rst;

  // checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_flush_pulse(sig);
    sig ##1 !sig;
  endsequence

  AST_STATUS_FLUSH: assert property (
    wr_tx && REG_WDATA_I[`TXC_STATUS_FLUSH_BIT] && !$past(wr_tx) |=> s_flush_pulse(TX_STATUS_FLUSH_O))
    else $error("status flush strobe did not pulse once after write");

  AST_DATA_FLUSH: assert property (
    (TX_DATA_FLUSH_O == $past(wr_tx && REG_WDATA_I[`TXC_DATA_FLUSH_BIT])) && (tx_cfg_read[14] == 1'b0))
    else $error("data flush strobe mismatched its write");

  AST_SUSPEND: assert property (
    TX_STATUS_FULL_I && !overrun_allow && !wr_tx && !soft_rst |=> TX_SUSPEND_O)
    else $error("transmitter not suspended on full status fifo");

  AST_FULL_EVENT: assert property (
    $rose(TX_STATUS_FULL_I) |=> TX_STATUS_FULL_EVENT_O ##1 !TX_STATUS_FULL_EVENT_O)
    else $error("status full event missing or stretched");

  AST_STOP_CLEARS: assert property (
    halt_done && !soft_rst |=> !TX_STOP_REQ_O && !TX_ENABLE_O)
    else $error("stop or enable not cleared after halt");

  AST_STOP_IGNORES: assert property (
    stop_tx && !TX_HALTED_I && !soft_rst |=> TX_STOP_REQ_O)
    else $error("stop bit changed by a write while high");

  AST_ENDIAN_KEPT: assert property (
    soft_rst && !wr_hw |=> $stable(PORT_PATH_ENDIAN_O) && $stable(DIRECT_PATH_ENDIAN_O))
    else $error("endian select lost over soft reset");

  AST_ALLOC_RANGE: assert property (
    (tx_allocation_size >= `ALLOC_MIN) && (tx_allocation_size <= `ALLOC_MAX))
    else $error("tx allocation outside 2 to 14");

  sequence s_software_reset_request_req_clocks_ok;
    software_reset_request_start ##1 phy_clks_run;
  endsequence

  AST_SOFTWARE_RESET_REQUEST_FIRES: assert property (
    s_software_reset_request_req_clocks_ok |=> SOFT_RESET_O ##1 !SOFT_RESET_O)
    else $error("soft reset pulse missing with phy clocks running");

  AST_SOFTWARE_RESET_REQUEST_TIMEOUT: assert property (
    tmo_hit |=> soft_reset_timeout && !software_reset_request_busy && !SOFT_RESET_O)
    else $error("soft reset timeout flag not set");

  AST_NO_FIRE_WITHOUT_CLK: assert property (
    (software_reset_request_state == SR_WAIT) && !phy_clks_run |=> !SOFT_RESET_O)
    else $error("soft reset fired without phy clocks");

  AST_TX_ENABLE_WRITE: assert property (
    wr_tx && !halt_done && !soft_rst |=> TX_ENABLE_O == $past(REG_WDATA_I[`TXC_ENABLE_BIT]))
    else $error("transmitter enable did not follow its write");

  AST_PORT_ENDIAN_WRITE: assert property (
    wr_hw |=> PORT_PATH_ENDIAN_O == $past(REG_WDATA_I[`HWC_PORT_ENDIAN_BIT]))
    else $error("port path endian did not follow its write");

  AST_DIRECT_ENDIAN_WRITE: assert property (
    wr_hw |=> DIRECT_PATH_ENDIAN_O == $past(REG_WDATA_I[`HWC_DIRECT_ENDIAN_BIT]))
    else $error("direct path endian did not follow its write");

endmodule
`default_nettype wire

// >>> tx_hardware_configuration_consts.svh
// offsets, field positions, reset values and timing counts for the transmit control and hardware config registers
// Notes on behaviour
// - writing one to transmit control bit 15 empties the TX status FIFO; bit self-clears.
// - writing one to transmit control bit 14 empties the TX data FIFO; bit self-clears.
// - bit 2 clear suspends transmission on full status FIFO; set lets it continue.
// - status-FIFO-full interrupt event is raised the same whatever bit 2 holds.
// - bit 1 set enables the transmitter to send queued data; resets to zero.
// - device clears transmitter enable once a stop was requested and transmitter halted.
// - bit 0 stops transmitter after current frame; device clears it once stopped.
// - while the stop bit reads one, writes to it are ignored.
// - hardware config bit 29 selects port path byte order, zero little, one big.
// - hardware config bit 28 selects direct-select path byte order, zero little, one big.
// - software reset clears system control registers but keeps the endian selects.
// - read-only bit 24 shows the sampled auto-crossover strap.
// - bits 19..16 give TX allocation in 1KB units, 2 to 14, reset 5.
// - TX status FIFO takes fixed 512 bytes; TX data FIFO takes the rest.
// - RX FIFOs take the leftover memory, 16KB minus the TX allocation.
// - soft reset without running PHY clocks times out and sets read-only bit 1.
// - writing one to hardware config bit 0 starts a soft reset; bit self-clears.
`ifndef TX_HARDWARE_CONFIGURATION_CONSTS_SVH
`define TX_HARDWARE_CONFIGURATION_CONSTS_SVH

`define TX_CTRL_OFFSET 8'h70
`define HARDWARE_CONFIGURATION_OFFSET 8'h74

`define TXC_STATUS_FLUSH_BIT 15
`define TXC_DATA_FLUSH_BIT 14
`define TXC_OVERRUN_ALLOW_BIT 2
`define TXC_ENABLE_BIT 1
`define TXC_STOP_BIT 0

`define HWC_PORT_ENDIAN_BIT 29
`define HWC_DIRECT_ENDIAN_BIT 28
`define HWC_STRAP_BIT 24
`define HWC_MBO_BIT 20
`define HWC_ALLOC_HI 19
`define HWC_ALLOC_LO 16
`define HWC_TIMEOUT_BIT 1
`define HWC_SOFTWARE_RESET_REQUEST_BIT 0

`define ALLOC_RESET 4'h5
`define ALLOC_MIN 4'h2
`define ALLOC_MAX 4'hE

`define TX_STATUS_FIFO_BYTES 15'h0200
`define FIFO_MEM_BYTES 15'h4000

`define CORE_CLK_MHZ 125
`define SOFTWARE_RESET_REQUEST_TIMEOUT_NS 2000
`define SOFTWARE_RESET_REQUEST_TIMEOUT_CYCLES ((`SOFTWARE_RESET_REQUEST_TIMEOUT_NS * `CORE_CLK_MHZ + 999) / 1000)

`endif

// >>> tx_hardware_configuration_pkg.sv
// types shared by the transmit control and hardware config register bank
`default_nettype none
package tx_hardware_configuration_pkg;
  typedef logic [3:0] alloc_size_t;
  typedef logic [14:0] fifo_bytes_t;
  typedef enum logic [2:0] {
    SR_IDLE = 3'b001,
    SR_WAIT = 3'b010,
    SR_FIRE = 3'b100
  } software_reset_request_state_t;
endpackage
`default_nettype wire

// >>> sync_2ff.sv
// two flip-flop synchroniser for pin-level inputs
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> tx_hardware_configuration_regs_tb.sv
// self-checking bench for the transmit control and hardware config register bank
`include "tx_hardware_configuration_consts.svh"
`default_nettype none
module tx_hardware_configuration_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tx_hardware_configuration_pkg::*;

  logic clk, rst_n, reg_wr, reg_rd, halted, full, strap, phy;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic rvalid, tx_en, stop_req, suspend, full_evt, s_flush, d_flush, pend, dend, mbo_o, software_reset_request;
  fifo_bytes_t data_b, stat_b, rx_b;
  int seed = 27;
  int n_mismatch = 0;
  int comparisons = 0;
  int evt_cnt = 0;
  int software_reset_request_cnt = 0;
  int m_stop, m_en, m_sao, m_pe, m_de, m_mbo, m_alloc, m_to, m_strap;

  // short timeout count keeps the stalled soft reset case brief
  tx_hardware_configuration_regs #(.SOFTWARE_RESET_REQUEST_TIMEOUT_CYCLES(8)) u_dut (
    .CORE_CLK_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .TX_HALTED_I(halted),
    .TX_STATUS_FULL_I(full), .TX_ENABLE_O(tx_en), .TX_STOP_REQ_O(stop_req), .TX_SUSPEND_O(suspend),
    .TX_STATUS_FULL_EVENT_O(full_evt), .TX_STATUS_FLUSH_O(s_flush), .TX_DATA_FLUSH_O(d_flush),
    .PORT_PATH_ENDIAN_O(pend), .DIRECT_PATH_ENDIAN_O(dend), .MUST_BE_ONE_O(mbo_o),
    .TX_DATA_FIFO_BYTES_O(data_b), .TX_STATUS_FIFO_BYTES_O(stat_b), .RX_FIFO_BYTES_O(rx_b),
    .AUTO_CROSSOVER_STRAP_I(strap), .PHY_CLKS_RUNNING_I(phy), .SOFT_RESET_O(software_reset_request));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (full_evt === 1'b1) evt_cnt++;
    if (software_reset_request === 1'b1) software_reset_request_cnt++;
  end

  function automatic logic [31:0] hw_exp();
    return {2'b00, m_pe[0], m_de[0], 3'b000, m_strap[0], 3'b000, m_mbo[0], m_alloc[3:0], 14'h0000, m_to[0], 1'b0};
  endfunction

  function automatic logic [31:0] tx_exp();
    return {29'h00000000, m_sao[0], m_en[0], m_stop[0]};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    q = rdata;
  endtask

  task automatic sizes();
    chk("tx_data_bytes", 32'(m_alloc * 1024 - 512), {17'h0, data_b});
    chk("tx_status_bytes", 32'h200, {17'h0, stat_b});
    chk("rx_bytes", 32'(16384 - m_alloc * 1024), {17'h0, rx_b});
  endtask

  // counts one soft reset pulse, bounded
  task automatic wait_software_reset_request(input int s0);
    for (int i = 0; i < 20 && software_reset_request_cnt == s0; i++) @(posedge clk);
    if (software_reset_request_cnt == s0) begin
      n_mismatch++;
      $display("FAIL soft_reset expected 1 seen 0");
      finish_test();
    end
    m_stop = 0; m_en = 0; m_sao = 0; m_mbo = 0; m_alloc = 5; m_to = 0;
  endtask

  initial begin
    logic [31:0] d, q;
    int e0, s0;
    rst_n = 1'b0; addr = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0; wdata = 32'h0; halted = 1'b0; full = 1'b0; phy = 1'b1;
    strap = 1'($random(seed));
    m_strap = strap; m_stop = 0; m_en = 0; m_sao = 0; m_pe = 0; m_de = 0; m_mbo = 0; m_alloc = 5; m_to = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    sizes();
    rd(`TX_CTRL_OFFSET, q); chk("tx_ctrl", tx_exp(), q);
    rd(`HARDWARE_CONFIGURATION_OFFSET, q); chk("hardware_configuration", hw_exp(), q);
    wr(8'h7C, 32'hFFFFFFFF);
    rd(8'h7C, q); chk("unmapped", 32'h0, q);
    // every allocation code, with random endian, must-be-one and reserved bits
    for (int c = 0; c < 16; c++) begin
      d = $random(seed);
      d[19:16] = c[3:0];
      d[0] = 1'b0;
      wr(`HARDWARE_CONFIGURATION_OFFSET, d);
      m_pe = d[29]; m_de = d[28]; m_mbo = d[20];
      if (c >= 2 && c <= 14) m_alloc = c;
      @(posedge clk);
      #1;
      chk("port_endian", 32'(m_pe), {31'h0, pend});
      chk("direct_endian", 32'(m_de), {31'h0, dend});
      chk("must_be_one", 32'(m_mbo), {31'h0, mbo_o});
      sizes();
      rd(`HARDWARE_CONFIGURATION_OFFSET, q); chk("hardware_configuration", hw_exp(), q);
    end
    wr(`TX_CTRL_OFFSET, 32'hFFFFC000);
    #1;
    chk("status_flush", 32'h1, {31'h0, s_flush});
    chk("data_flush", 32'h1, {31'h0, d_flush});
    rd(`TX_CTRL_OFFSET, q); chk("tx_ctrl", tx_exp(), q);
    for (int s = 0; s < 2; s++) begin
      wr(`TX_CTRL_OFFSET, 32'(s << 2));
      m_sao = s;
      e0 = evt_cnt;
      full <= 1'b1;
      @(posedge clk);
      #1;
      chk("suspend", 32'(s == 0), {31'h0, suspend});
      repeat (3) @(posedge clk);
      full <= 1'b0;
      @(posedge clk);
      #1;
      chk("full_event", 32'h1, 32'(evt_cnt - e0));
    end
    wr(`TX_CTRL_OFFSET, 32'h3);
    m_en = 1; m_stop = 1; m_sao = 0;
    #1;
    chk("tx_enable", 32'h1, {31'h0, tx_en});
    chk("stop_req", 32'h1, {31'h0, stop_req});
    wr(`TX_CTRL_OFFSET, 32'h2);
    rd(`TX_CTRL_OFFSET, q); chk("tx_ctrl", tx_exp(), q);
    @(posedge clk);
    halted <= 1'b1;
    @(posedge clk);
    #1;
    m_en = 0; m_stop = 0;
    chk("tx_enable", 32'h0, {31'h0, tx_en});
    chk("stop_req", 32'h0, {31'h0, stop_req});
    @(posedge clk);
    halted <= 1'b0;
    // soft reset clears transmit control, must-be-one and allocation but keeps the endian selects
    wr(`TX_CTRL_OFFSET, 32'h4);
    wr(`HARDWARE_CONFIGURATION_OFFSET, 32'h20190000);
    m_pe = 1; m_de = 0; m_mbo = 1; m_alloc = 9;
    s0 = software_reset_request_cnt;
    wr(`HARDWARE_CONFIGURATION_OFFSET, hw_exp() | 32'h1);
    wait_software_reset_request(s0);
    rd(`TX_CTRL_OFFSET, q); chk("tx_ctrl", tx_exp(), q);
    rd(`HARDWARE_CONFIGURATION_OFFSET, q); chk("hardware_configuration", hw_exp(), q);
    // stalled phy clocks: no pulse, timeout flag instead
    @(posedge clk);
    phy <= 1'b0;
    repeat (4) @(posedge clk);
    s0 = software_reset_request_cnt;
    wr(`HARDWARE_CONFIGURATION_OFFSET, hw_exp() | 32'h1);
    q = 32'h0;
    for (int i = 0; i < 40 && q[1] !== 1'b1; i++) rd(`HARDWARE_CONFIGURATION_OFFSET, q);
    if (q[1] !== 1'b1) begin
      n_mismatch++;
      $display("FAIL soft_reset_timeout expected 1 seen 0");
      finish_test();
    end
    m_to = 1;
    chk("hardware_configuration", hw_exp(), q);
    chk("soft_resets", 32'(s0), 32'(software_reset_request_cnt));
    @(posedge clk);
    phy <= 1'b1;
    repeat (4) @(posedge clk);
    wr(`HARDWARE_CONFIGURATION_OFFSET, hw_exp() | 32'h1);
    wait_software_reset_request(s0);
    rd(`HARDWARE_CONFIGURATION_OFFSET, q); chk("hardware_configuration", hw_exp(), q);
    finish_test();
  end
endmodule
`default_nettype wire
